//--- hdl/btr_regs.sv
// Trim readback and OTP window register group of the buck driver
`timescale 1ns/10ps
`default_nettype none

// How it works
// (R1) Bit 8 of each trim word is odd parity over its trim bits.
// (R2) Bank select 0 shows channel one deltas, 1 shows channel two deltas.
// (R3) Delta fields are 4-bit two's complement, range -8 to 7.
// (R4) Deltas are offsets from the range 5 hot trim constant, not absolute.
// (R5) Channel one tempco word: high nibble ranges 3-5, low nibble ranges 1-2.
// (R6) Channel two tempco word: high nibble ranges 3-5, low nibble ranges 1-2.
// (R7) After refresh, window shows the 10-bit OTP slice picked by 2-bit address.
// (R8) Operation code 0x1 reloads all 40 OTP bits before the window is valid.
// (R9) OTP active status stays 1 while an OTP operation runs.
// (R10) Undefined-reset trim fields come from manufacturing trim caught after reset.
// (R11) All registers read-only; writes ignored; unused bits read zero.
module btr_regs (
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    input  wire logic [4:0]                regAddr,
    input  wire logic                      regRead,
    input  wire logic                      regWrite,
    output logic      [9:0]                regRdData,
    output logic                           regRdValid,
    input  wire logic                      bankSel,
    input  wire logic [1:0]                otpAddr,
    input  wire logic [1:0]                otpOperation,
    input  wire logic                      otpOpStrobe,
    input  wire btr_pkg::btr_trim_t        factoryTrim,
    input  wire logic [39:0]               otpFuse,
    output logic                           otpActive
);

    function automatic logic [9:0] trimWord(input logic [7:0] bits);
        trimWord = {1'b0, ~^bits, bits}; // R1
    endfunction

    btr_pkg::btr_trim_t     trim_reg;
    logic                   trimLoaded_reg;
    btr_pkg::btr_otp_state_t otpState_reg;
    logic [5:0]             otpIdx_reg;
    logic [39:0]            otpShadow_reg;
    logic                   otpValid_reg;
    logic [9:0]             otpWindow_reg;
    logic [9:0]             otpWindow_next;
    btr_pkg::btr_delta_t    bankDelta;
    logic [9:0]             rdWord;
    logic                   refreshReq;
    logic                   readTaken;

    // Trim captured by a clocked process after reset release, not by the reset itself
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_reg <= '0;
        end else if (!trimLoaded_reg) begin
            trim_reg <= factoryTrim; // R10
        end
    end

    // One capture only; later changes on the trim input are ignored
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            trimLoaded_reg <= 1'b0;
        end else begin
            trimLoaded_reg <= 1'b1;
        end
    end

    // Refresh decode, shared by the sequencer, the index, the valid flag and busy
    assign refreshReq = otpOpStrobe && (otpOperation == btr_pkg::OTP_OP_REFRESH); // R8

    // Sequencer: idle, a single load state held one clock per fuse bit, then a closing state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            otpState_reg <= btr_pkg::OTP_IDLE;
        end else begin
            unique case (otpState_reg)
                btr_pkg::OTP_IDLE: begin
                    // Only refresh is handled here; other codes act as no operation
                    if (refreshReq) begin // R8
                        otpState_reg <= btr_pkg::OTP_LOAD;
                    end
                end
                btr_pkg::OTP_LOAD: begin
                    if (otpIdx_reg == btr_pkg::OTP_LAST_IDX) begin
                        otpState_reg <= btr_pkg::OTP_DONE;
                    end
                end
                btr_pkg::OTP_DONE: begin
                    otpState_reg <= btr_pkg::OTP_IDLE;
                end
                default: begin
                    otpState_reg <= btr_pkg::OTP_IDLE;
                end
            endcase
        end
    end

    // Fuse bit index: cleared by a taken refresh, stepped while loading
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            otpIdx_reg <= '0;
        end else if (otpState_reg == btr_pkg::OTP_IDLE && refreshReq) begin
            otpIdx_reg <= '0;
        end else if (otpState_reg == btr_pkg::OTP_LOAD && otpIdx_reg != btr_pkg::OTP_LAST_IDX) begin
            otpIdx_reg <= otpIdx_reg + 6'h01;
        end
    end

    // Refresh walks the fuse array one bit per clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            otpShadow_reg <= btr_pkg::RESET_OTP;
        end else if (otpState_reg == btr_pkg::OTP_LOAD) begin
            otpShadow_reg[otpIdx_reg] <= otpFuse[otpIdx_reg]; // R8
        end
    end

    // Window stays blank from a taken refresh until every bit is in
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            otpValid_reg <= 1'b0;
        end else if (otpState_reg == btr_pkg::OTP_IDLE && refreshReq) begin
            otpValid_reg <= 1'b0;
        end else if (otpState_reg == btr_pkg::OTP_DONE) begin
            otpValid_reg <= 1'b1; // R8
        end
    end

    // Busy rises with the taken strobe, so no idle gap shows before loading starts
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            otpActive <= 1'b0;
        end else begin
            otpActive <= (otpState_reg != btr_pkg::OTP_IDLE) || refreshReq; // R9
        end
    end

    always_comb begin
        otpWindow_next = btr_pkg::RESET_WORD;
        if (otpValid_reg) begin
            unique case (otpAddr)
                2'h0: begin
                    otpWindow_next = otpShadow_reg[9:0]; // R7
                end
                2'h1: begin
                    otpWindow_next = otpShadow_reg[19:10]; // R7
                end
                2'h2: begin
                    otpWindow_next = otpShadow_reg[29:20]; // R7
                end
                2'h3: begin
                    otpWindow_next = otpShadow_reg[39:30]; // R7
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            otpWindow_reg <= btr_pkg::RESET_WORD;
        end else begin
            otpWindow_reg <= otpWindow_next;
        end
    end

    // Deltas pass through unaltered: signed offsets from the range 5 hot constant
    assign bankDelta = bankSel ? trim_reg.channelTwo : trim_reg.channelOne; // R2 R3 R4

    always_comb begin
        rdWord = btr_pkg::RESET_WORD; // R11
        unique case (regAddr)
            btr_pkg::OFS_DELTA_LOW: begin
                rdWord = trimWord({bankDelta.peakDeltaSecond, bankDelta.peakDeltaFirst}); // R2
            end
            btr_pkg::OFS_DELTA_HIGH: begin
                rdWord = trimWord({bankDelta.peakDeltaFourth, bankDelta.peakDeltaThird}); // R2
            end
            btr_pkg::OFS_TEMPCO_CH1: begin
                rdWord = trimWord({trim_reg.tempco.ch1HighRangeTempco,
                                   trim_reg.tempco.ch1LowRangeTempco}); // R5
            end
            btr_pkg::OFS_TEMPCO_CH2: begin
                rdWord = trimWord({trim_reg.tempco.ch2HighRangeTempco,
                                   trim_reg.tempco.ch2LowRangeTempco}); // R6
            end
            btr_pkg::OFS_TEMPCO_SPARE: begin
                rdWord = trimWord({btr_pkg::RESET_NIBBLE, trim_reg.spareTempco});
            end
            btr_pkg::OFS_OTP_WINDOW: begin
                rdWord = otpWindow_reg; // R7
            end
            default: begin
                rdWord = btr_pkg::RESET_WORD; // R11
            end
        endcase
    end

    // Writes never touch any register here; regWrite only suppresses a clashing read
    assign readTaken = regRead && !regWrite; // R11

    // Valid marks exactly one cycle per taken read
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= readTaken; // R11
        end
    end

    // Data holds the last answer until the next taken read
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= btr_pkg::RESET_WORD;
        end else if (readTaken) begin
            regRdData <= rdWord;
        end
    end

endmodule // btr_regs

`default_nettype wire

//--- include/btr_pkg.sv
// Package for the trim and OTP readback register group
`default_nettype none
package btr_pkg;
    localparam int          REG_ADDR_W        = 5;
    localparam int          REG_DATA_W        = 10;
    localparam int          OTP_BITS          = 40;
    localparam int          OTP_SLICE_W       = 10;
    localparam int          OTP_IDX_W         = 6;

    localparam logic [4:0]  OFS_DELTA_LOW     = 5'h19;
    localparam logic [4:0]  OFS_DELTA_HIGH    = 5'h1A;
    localparam logic [4:0]  OFS_TEMPCO_CH1    = 5'h1B;
    localparam logic [4:0]  OFS_TEMPCO_CH2    = 5'h1C;
    localparam logic [4:0]  OFS_TEMPCO_SPARE  = 5'h1D;
    localparam logic [4:0]  OFS_OTP_WINDOW    = 5'h1E;

    localparam int          PARITY_POS        = 8;
    localparam int          HIGH_NIBBLE_LSB   = 4;
    localparam int          LOW_NIBBLE_LSB    = 0;

    localparam logic [1:0]  OTP_OP_REFRESH    = 2'h1;
    localparam logic [5:0]  OTP_LAST_IDX      = 6'h27;

    localparam logic [9:0]  RESET_WORD        = 10'h000;
    localparam logic [3:0]  RESET_NIBBLE      = 4'h0;
    localparam logic [39:0] RESET_OTP         = 40'h00_0000_0000;

    // Peak-current deltas of one buck channel, signed two's complement
    typedef struct packed {
        logic signed [3:0] peakDeltaFourth;
        logic signed [3:0] peakDeltaThird;
        logic signed [3:0] peakDeltaSecond;
        logic signed [3:0] peakDeltaFirst;
    } btr_delta_t;

    // Temperature coefficients, signed two's complement
    typedef struct packed {
        logic signed [3:0] ch2HighRangeTempco;
        logic signed [3:0] ch2LowRangeTempco;
        logic signed [3:0] ch1HighRangeTempco;
        logic signed [3:0] ch1LowRangeTempco;
    } btr_tempco_t;

    typedef struct packed {
        btr_delta_t  channelOne;
        btr_delta_t  channelTwo;
        btr_tempco_t tempco;
        logic [3:0]  spareTempco;
    } btr_trim_t;

    typedef enum logic [1:0] {
        OTP_IDLE = 2'b00,
        OTP_LOAD = 2'b01,
        OTP_DONE = 2'b11
    } btr_otp_state_t;
endpackage : btr_pkg
`default_nettype wire

//--- test/btr_regs_assertions.sv
// Port-level checker for the trim and OTP readback register group
`timescale 1ns/10ps
`default_nettype none
module btr_regs_assertions (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic [4:0] regAddr,
    input wire logic       regRead,
    input wire logic       regWrite,
    input wire logic [9:0] regRdData,
    input wire logic       regRdValid,
    input wire logic [1:0] otpOperation,
    input wire logic       otpOpStrobe,
    input wire logic       otpActive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_read_answered: assert property (regRead && !regWrite |=> regRdValid) else $error("read lost");
    a_write_no_valid: assert property (regWrite |=> !regRdValid) else $error("write gave data");
    a_parity_odd: assert property (regRdValid && $past(regAddr) inside {[5'h19:5'h1D]} |-> ^regRdData[8:0])
        else $error("even parity");
    a_top_bit_zero: assert property (regRdValid && $past(regAddr) != 5'h1E |-> !regRdData[9])
        else $error("bit 9 set");
    a_unmapped_zero: assert property (regRdValid && !($past(regAddr) inside {[5'h19:5'h1E]}) |-> regRdData == 10'h000)
        else $error("unmapped not zero");
    a_refresh_starts: assert property (otpOpStrobe && otpOperation == 2'h1 && !otpActive && !$past(otpActive)
        |=> otpActive) else $error("refresh not started");
    a_active_cause: assert property ($rose(otpActive) |-> $past(otpOpStrobe) && $past(otpOperation) == 2'h1)
        else $error("active without refresh");
    a_active_holds: assert property ($rose(otpActive) |-> otpActive[*8] ##[32:36] !otpActive)
        else $error("active length wrong");
    // Busy time counted in helper logic: a gap in the middle would slip past a windowed check
    localparam int ACTIVE_CYCLES = 42;
    logic [7:0] activeCycles;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            activeCycles <= 8'h00;
        end else if (otpActive) begin
            activeCycles <= activeCycles + 8'h01;
        end else begin
            activeCycles <= 8'h00;
        end
    end
    a_active_length: assert property ($fell(otpActive) |-> activeCycles == ACTIVE_CYCLES)
        else $error("refresh busy time wrong");
endmodule // btr_regs_assertions
bind btr_regs btr_regs_assertions chk (.ref_clk, .arst_n, .regAddr, .regRead, .regWrite, .regRdData,
    .regRdValid, .otpOperation, .otpOpStrobe, .otpActive);
`default_nettype wire

//--- test/test_btr_regs.sv
// Self-checking bench for the trim and OTP readback register group
`timescale 1ns/10ps
`default_nettype none
module test_btr_regs;
    logic               ref_clk = 1'b0, arst_n = 1'b0, regRead = 1'b0, regWrite = 1'b0, bankSel = 1'b0;
    logic               otpOpStrobe = 1'b0, regRdValid, otpActive;
    logic [4:0]         regAddr = 5'h00;
    logic [1:0]         otpAddr = 2'h0, otpOperation = 2'h0;
    logic [9:0]         regRdData;
    logic [39:0]        otpFuse;
    logic [63:0]        r;
    logic [15:0]        seed = 16'h001F;
    btr_pkg::btr_trim_t factoryTrim;
    btr_pkg::btr_delta_t d;
    int                 fails = 0, totalChecks = 0, cycles = 0;
    always #4 ref_clk = ~ref_clk;
    btr_regs uut (.ref_clk, .arst_n, .regAddr, .regRead, .regWrite, .regRdData, .regRdValid, .bankSel,
                  .otpAddr, .otpOperation, .otpOpStrobe, .factoryTrim, .otpFuse, .otpActive);
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    // Odd parity over the eight trim bits
    function automatic logic [9:0] word(input logic [3:0] hi, input logic [3:0] lo);
        return {1'b0, ~^{hi, lo}, hi, lo};
    endfunction
    function automatic logic [9:0] model(input logic [4:0] a);
        d = bankSel ? factoryTrim.channelTwo : factoryTrim.channelOne;
        case (a)
            5'h19: return word(d.peakDeltaSecond, d.peakDeltaFirst);
            5'h1A: return word(d.peakDeltaFourth, d.peakDeltaThird);
            5'h1B: return word(factoryTrim.tempco.ch1HighRangeTempco, factoryTrim.tempco.ch1LowRangeTempco);
            5'h1C: return word(factoryTrim.tempco.ch2HighRangeTempco, factoryTrim.tempco.ch2LowRangeTempco);
            5'h1D: return word(4'h0, factoryTrim.spareTempco);
            default: return 10'h000;
        endcase
    endfunction
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] seen);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [9:0] exp);
        @(posedge ref_clk) #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge ref_clk) #1;
        regRead = 1'b0;
        chk("valid", 10'h001, {9'h000, regRdValid});
        chk("data", exp, regRdData);
    endtask
    task automatic report_and_stop();
        if (fails == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        r = {rnd(), rnd(), rnd(), rnd()};
        factoryTrim = r[51:0];
        // Both ends of the signed range
        factoryTrim.channelOne.peakDeltaFirst = 4'h8;
        factoryTrim.channelOne.peakDeltaSecond = 4'h7;
        r = {rnd(), rnd(), rnd(), rnd()};
        otpFuse = r[39:0];
        repeat (16) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        repeat (2) @(posedge ref_clk) #1;
        for (int b = 0; b < 2; b++) begin
            bankSel = b[0];
            // Unmapped neighbours and the blank window included
            for (int a = 8'h17; a < 8'h21; a++) rd(a[4:0], model(a[4:0]));
        end
        @(posedge ref_clk) #1;
        regWrite = 1'b1;
        regRead = 1'b1;
        @(posedge ref_clk) #1;
        regWrite = 1'b0;
        regRead = 1'b0;
        chk("dropped read", 10'h000, {9'h000, regRdValid});
        rd(5'h19, model(5'h19));
        for (int op = 0; op < 4; op++) begin
            @(posedge ref_clk) #1;
            otpOperation = op[1:0];
            otpOpStrobe = 1'b1;
            @(posedge ref_clk) #1;
            otpOpStrobe = 1'b0;
            chk("otp active", {9'h000, op == 1}, {9'h000, otpActive});
            if (op == 1) begin
                rd(5'h1E, 10'h000);
                for (int n = 0; n < 60 && otpActive !== 1'b0; n++) @(posedge ref_clk) #1;
                repeat (3) @(posedge ref_clk) #1;
                for (int a = 0; a < 4; a++) begin
                    otpAddr = a[1:0];
                    rd(5'h1E, otpFuse[a * 10 +: 10]);
                end
            end
        end
        report_and_stop();
    end
endmodule // test_btr_regs
`default_nettype wire
